// ===== hdl/tcr_pace.sv
// free-running period ticker
`timescale 1ns/1ps
module tcr_pace import tcr_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire tcr_cnt_t period,
	output logic tick
);
	typedef struct packed {
		tcr_cnt_t cnt;
		logic tick;
	} tcr_pace_s;
	localparam tcr_pace_s TCR_PACE_RST = '{cnt: '0, tick: 1'b0};
	tcr_pace_s q, d;

	// ****************************************
	// counter
	// ****************************************
	always_comb begin
		d = q;
		d.tick = 1'b0;
		// >= so a shortened period takes effect at once
		if (q.cnt >= period - tcr_cnt_t'(1)) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + tcr_cnt_t'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= TCR_PACE_RST;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	tick_restart_a: assert property (q.tick |-> q.cnt == '0)
		else $error("tick without counter restart");
endmodule

// ===== hdl/tcr_pkg.sv
// shared constants and types of the thermocouple channel readout
package tcr_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int TCR_CLK_HZ = 25_000_000;
	localparam int TCR_CYC_PER_MS = TCR_CLK_HZ / 1000;
	localparam int TCR_CYC_PER_US = TCR_CLK_HZ / 1_000_000;
	localparam int TCR_CNT_W = 24;
	typedef logic [TCR_CNT_W-1:0] tcr_cnt_t;
	localparam int TCR_T_EXT_MS = 20;
	localparam int TCR_T_EXT_LF_MS = 80;
	localparam int TCR_T_INT_MS = 120;
	localparam int TCR_T_INT_LF_MS = 240;
	localparam int TCR_T_SEND_US = 6500;
	localparam tcr_cnt_t TCR_N_EXT = tcr_cnt_t'(TCR_T_EXT_MS * TCR_CYC_PER_MS);
	localparam tcr_cnt_t TCR_N_EXT_LF = tcr_cnt_t'(TCR_T_EXT_LF_MS * TCR_CYC_PER_MS);
	localparam tcr_cnt_t TCR_N_INT = tcr_cnt_t'(TCR_T_INT_MS * TCR_CYC_PER_MS);
	localparam tcr_cnt_t TCR_N_INT_LF = tcr_cnt_t'(TCR_T_INT_LF_MS * TCR_CYC_PER_MS);
	localparam tcr_cnt_t TCR_N_SEND = tcr_cnt_t'(TCR_T_SEND_US * TCR_CYC_PER_US);
	// ****************************************
	// ramp filter: one count of full scale per interval
	// ****************************************
	localparam int TCR_VAL_W = 12;
	localparam longint TCR_FS_COUNTS = 4096;
	localparam longint TCR_PCT_FULL = 100;
	localparam longint TCR_RATE_FAST_PCT = 100;
	localparam longint TCR_RATE_MID_PCT = 10;
	localparam longint TCR_RATE_SLOW_PCT = 1;
	localparam tcr_cnt_t TCR_N_RAMP_FAST = tcr_cnt_t'((longint'(TCR_CLK_HZ) * TCR_PCT_FULL)
		/ (TCR_FS_COUNTS * TCR_RATE_FAST_PCT));
	localparam tcr_cnt_t TCR_N_RAMP_MID = tcr_cnt_t'((longint'(TCR_CLK_HZ) * TCR_PCT_FULL)
		/ (TCR_FS_COUNTS * TCR_RATE_MID_PCT));
	localparam tcr_cnt_t TCR_N_RAMP_SLOW = tcr_cnt_t'((longint'(TCR_CLK_HZ) * TCR_PCT_FULL)
		/ (TCR_FS_COUNTS * TCR_RATE_SLOW_PCT));
	typedef enum logic [1:0] {
		TCR_FLT_OFF = 2'h0,
		TCR_FLT_FAST = 2'h1,
		TCR_FLT_MID = 2'h2,
		TCR_FLT_SLOW = 2'h3
	} tcr_flt_e;
	// ****************************************
	// parameter byte layout
	// ****************************************
	localparam int TCR_PRM_W = 5;
	localparam int TCR_PB_LFD = 0;
	localparam int TCR_PB_FLT_LO = 1;
	localparam int TCR_PB_FLT_HI = 2;
	localparam int TCR_PB_CJ_EXT = 3;
	localparam int TCR_PB_CJ_50 = 4;
	localparam logic [TCR_PRM_W-1:0] TCR_PRM_RESET = 5'h00;
	localparam logic [7:0] TCR_PRM_HEADER = 8'h52;
	localparam logic [7:0] TCR_CFG_CODE = 8'h50;
	localparam logic [7:0] TCR_IN_BYTES = 8'h02;
	localparam logic [7:0] TCR_OUT_BYTES = 8'h00;
	// ****************************************
	// channel word layout and fault release
	// ****************************************
	localparam int TCR_WB_FAULT = 1;
	localparam int TCR_WB_VAL_LO = 4;
	localparam logic [15:0] TCR_WORD_RESET = 16'h0000;
	localparam logic [3:0] TCR_GOOD_NEED = 4'ha;
endpackage

// ===== hdl/tcr_ramp.sv
// linear rate-limiting filter for the measured value
`timescale 1ns/1ps
module tcr_ramp import tcr_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [TCR_VAL_W-1:0] target,
	input wire logic load,
	input wire tcr_flt_e code,
	input wire tcr_cnt_t n_fast,
	input wire tcr_cnt_t n_mid,
	input wire tcr_cnt_t n_slow,
	output logic [TCR_VAL_W-1:0] value
);
	typedef struct packed {
		logic [TCR_VAL_W-1:0] tgt;
		logic [TCR_VAL_W-1:0] val;
		tcr_cnt_t cnt;
	} tcr_ramp_s;
	localparam tcr_ramp_s TCR_RAMP_RST = '{tgt: '0, val: '0, cnt: '0};
	tcr_ramp_s q, d;
	tcr_cnt_t step_n;

	// ****************************************
	// step logic
	// ****************************************
	always_comb begin
		d = q;
		case (code)
			TCR_FLT_FAST: step_n = n_fast;
			TCR_FLT_MID: step_n = n_mid;
			default: step_n = n_slow;
		endcase
		if (load) begin
			d.tgt = target;
		end
		if (code == TCR_FLT_OFF) begin
			d.val = d.tgt;
			d.cnt = '0;
		end else if (q.cnt >= step_n - tcr_cnt_t'(1)) begin
			d.cnt = '0;
			if (q.val < q.tgt) begin
				d.val = q.val + 1'b1;
			end else if (q.val > q.tgt) begin
				d.val = q.val - 1'b1;
			end
		end else begin
			d.cnt = q.cnt + tcr_cnt_t'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= TCR_RAMP_RST;
		end else begin
			q <= d;
		end
	end

	assign value = q.val;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	ramp_step_a: assert property (code != TCR_FLT_OFF |=>
		(q.val == $past(q.val) || q.val == $past(q.val) + 1'b1 || q.val == $past(q.val) - 1'b1))
		else $error("filtered value moved by more than one count");
	ramp_off_a: assert property (load && code == TCR_FLT_OFF |=> q.val == $past(target))
		else $error("unfiltered value did not follow target");
	ramp_move_c: cover property (code != TCR_FLT_OFF && q.val != q.tgt ##1 $changed(q.val));
endmodule

// ===== hdl/tcr_readout.sv
// thermocouple channel readout: parameters, measurement pacing, line fault, channel word
`timescale 1ns/1ps
module tcr_readout import tcr_pkg::*; #(
	parameter tcr_cnt_t N_EXT = TCR_N_EXT,
	parameter tcr_cnt_t N_EXT_LF = TCR_N_EXT_LF,
	parameter tcr_cnt_t N_INT = TCR_N_INT,
	parameter tcr_cnt_t N_INT_LF = TCR_N_INT_LF,
	parameter tcr_cnt_t N_SEND = TCR_N_SEND,
	parameter tcr_cnt_t N_RAMP_FAST = TCR_N_RAMP_FAST,
	parameter tcr_cnt_t N_RAMP_MID = TCR_N_RAMP_MID,
	parameter tcr_cnt_t N_RAMP_SLOW = TCR_N_RAMP_SLOW
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic conv_done,
	input wire logic [TCR_VAL_W-1:0] conv_value,
	input wire logic line_break_pin,
	input wire logic prm_valid,
	input wire logic [7:0] prm_header,
	input wire logic [7:0] prm_data1,
	input wire logic [7:0] prm_data2,
	output logic [15:0] chan_word,
	output logic word_strobe,
	output logic conv_start,
	output logic diag_fault,
	output logic cjc_ext_sel,
	output logic cjc_ref_50c,
	output logic cjc_comp_en,
	output logic [7:0] cfg_code,
	output logic [7:0] cfg_in_bytes,
	output logic [7:0] cfg_out_bytes
);
	// ****************************************
	// types and state
	// ****************************************
	typedef enum logic [1:0] {
		TCR_MS_WAIT = 2'b01,
		TCR_MS_CONV = 2'b10
	} tcr_ms_e;

	typedef struct packed {
		tcr_ms_e st;
		logic [TCR_PRM_W-1:0] prm;
		logic brk_s1;
		logic brk_s2;
		logic fault;
		logic [3:0] good_cnt;
		logic [TCR_VAL_W-1:0] tgt;
		logic tgt_ld;
		logic start;
		logic send;
		logic [15:0] word;
	} tcr_main_s;

	localparam tcr_main_s TCR_MAIN_RST = '{
		st: TCR_MS_WAIT,
		prm: TCR_PRM_RESET,
		brk_s1: 1'b0,
		brk_s2: 1'b0,
		fault: 1'b0,
		good_cnt: 4'h0,
		tgt: '0,
		tgt_ld: 1'b0,
		start: 1'b0,
		send: 1'b0,
		word: TCR_WORD_RESET
	};

	tcr_main_s q, d;
	logic meas_tick;
	logic send_tick;
	logic lfd_on;
	logic cj_ext;
	tcr_cnt_t meas_period;
	logic [TCR_VAL_W-1:0] ramp_val;

	// ****************************************
	// functions
	// ****************************************
	function automatic tcr_cnt_t tcr_period(input logic ext, input logic lfd);
		tcr_cnt_t p;
		p = N_INT;
		case ({ext, lfd})
			2'b10: p = N_EXT;
			2'b11: p = N_EXT_LF;
			2'b01: p = N_INT_LF;
			default: p = N_INT;
		endcase
		return p;
	endfunction

	// status nibble starts from the all-zero reset word
	// the low nibble is status; only the fault bit is ever set
	function automatic logic [15:0] tcr_word(input logic [TCR_VAL_W-1:0] v, input logic f);
		logic [15:0] w;
		w = TCR_WORD_RESET;
		w[15:TCR_WB_VAL_LO] = v;
		w[TCR_WB_FAULT] = f;
		return w;
	endfunction

	assign lfd_on = q.prm[TCR_PB_LFD];
	assign cj_ext = q.prm[TCR_PB_CJ_EXT];
	assign meas_period = tcr_period(cj_ext, lfd_on);

	// ****************************************
	// pacing and filter
	// ****************************************
	tcr_pace u_meas_pace (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.period(meas_period),
		.tick(meas_tick)
	);

	tcr_pace u_send_pace (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.period(N_SEND),
		.tick(send_tick)
	);

	tcr_ramp u_ramp (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.target(q.tgt),
		.load(q.tgt_ld),
		.code(tcr_flt_e'(q.prm[TCR_PB_FLT_HI:TCR_PB_FLT_LO])),
		.n_fast(N_RAMP_FAST),
		.n_mid(N_RAMP_MID),
		.n_slow(N_RAMP_SLOW),
		.value(ramp_val)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d = q;
		d.brk_s1 = line_break_pin;
		d.brk_s2 = q.brk_s1;
		d.start = 1'b0;
		d.tgt_ld = 1'b0;
		d.send = 1'b0;
		// accept parameters only behind the right header
		if (prm_valid && prm_header == TCR_PRM_HEADER) begin
			// reserved bits 7:5 dropped, data byte 2 all reserved
			d.prm = prm_data1[TCR_PRM_W-1:0];
		end
		case (q.st)
			TCR_MS_WAIT: begin
				// period picked by junction and detection
				if (meas_tick) begin
					d.start = 1'b1;
					d.st = TCR_MS_CONV;
				end
			end
			TCR_MS_CONV: begin
				if (conv_done) begin
					d.st = TCR_MS_WAIT;
					if (!lfd_on) begin
						d.tgt = conv_value;
						d.tgt_ld = 1'b1;
					end else if (q.brk_s2) begin
						d.fault = 1'b1;
						d.good_cnt = 4'h0;
					end else if (q.fault) begin
						if (q.good_cnt == TCR_GOOD_NEED - 4'h1) begin
							d.fault = 1'b0;
							d.good_cnt = 4'h0;
							d.tgt = conv_value;
							d.tgt_ld = 1'b1;
						end else begin
							d.good_cnt = q.good_cnt + 4'h1;
						end
					end else begin
						d.tgt = conv_value;
						d.tgt_ld = 1'b1;
					end
				end
			end
			default: begin
				d.st = TCR_MS_WAIT;
			end
		endcase
		// detection off clears any fault state
		if (!lfd_on) begin
			d.fault = 1'b0;
			d.good_cnt = 4'h0;
		end
		// word latched and sent on the fixed interval
		if (send_tick) begin
			d.send = 1'b1;
			// value in the upper twelve bits
			d.word = tcr_word(ramp_val, q.fault);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= TCR_MAIN_RST;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// one 16-bit word
	assign chan_word = q.word;
	assign word_strobe = q.send;
	assign conv_start = q.start;
	assign diag_fault = q.fault;
	assign cjc_ext_sel = cj_ext;
	// reference temperature only meaningful with external junction
	assign cjc_ref_50c = cj_ext & q.prm[TCR_PB_CJ_50];
	// external at 0 degC measures raw millivolts
	assign cjc_comp_en = ~(cj_ext & ~q.prm[TCR_PB_CJ_50]);
	assign cfg_code = TCR_CFG_CODE;
	assign cfg_in_bytes = TCR_IN_BYTES;
	assign cfg_out_bytes = TCR_OUT_BYTES;

	// ****************************************
	// checks
	// ****************************************
	tcr_cnt_t m_gap;
	logic m_seen;
	logic m_same;
	tcr_cnt_t s_gap;
	logic s_seen;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			m_gap <= '0;
			m_seen <= 1'b0;
			m_same <= 1'b0;
			s_gap <= '0;
			s_seen <= 1'b0;
		end else begin
			m_gap <= meas_tick ? '0 : m_gap + tcr_cnt_t'(1);
			m_seen <= m_seen | meas_tick;
			m_same <= meas_tick ? 1'b1 : (m_same & (d.prm == q.prm));
			s_gap <= send_tick ? '0 : s_gap + tcr_cnt_t'(1);
			s_seen <= s_seen | send_tick;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	meas_period_a: assert property (meas_tick && m_seen && m_same
		|-> m_gap == meas_period - 1)
		else $error("measurement period wrong for selected mode");
	send_period_a: assert property (send_tick && s_seen |-> s_gap == N_SEND - 1)
		else $error("send interval wrong");
	word_hold_a: assert property ($changed(chan_word) |-> word_strobe)
		else $error("channel word changed between sends");
	status_zero_a: assert property (chan_word[0] == 1'b0 && chan_word[3:2] == 2'b00)
		else $error("empty status bits not zero");
	fault_bit_a: assert property (word_strobe |-> chan_word[TCR_WB_FAULT] == $past(q.fault))
		else $error("fault bit does not match fault state");
	value_bits_a: assert property (word_strobe
		|-> chan_word[15:TCR_WB_VAL_LO] == $past(ramp_val))
		else $error("measured value misplaced in word");
	lfd_off_a: assert property (!$past(lfd_on) |-> !q.fault)
		else $error("fault flagged with detection off");
	fault_hold_a: assert property (q.tgt_ld |-> !q.fault)
		else $error("value released while faulted");
	release_cnt_a: assert property ($fell(q.fault) && lfd_on && $past(lfd_on)
		|-> $past(q.good_cnt) == TCR_GOOD_NEED - 1)
		else $error("fault released before ten clean cycles");
	hdr_check_a: assert property (prm_valid && prm_header != TCR_PRM_HEADER
		|=> $stable(q.prm))
		else $error("parameters taken with wrong header");
	cjc_raw_a: assert property (prm_valid && prm_header == TCR_PRM_HEADER
		&& prm_data1[TCR_PB_CJ_EXT] && !prm_data1[TCR_PB_CJ_50] |=> !cjc_comp_en && cjc_ext_sel)
		else $error("compensation still on for external 0 degC");

	fault_release_c: cover property ($fell(q.fault) && lfd_on);
	send_c: cover property (word_strobe && chan_word[TCR_WB_FAULT]);
	ext_mode_c: cover property (conv_start && cj_ext && lfd_on);
endmodule

// ===== tb/tcr_conv_model.sv
// behavioural converter standing at the far side of the readout
`timescale 1ns/1ps
module tcr_conv_model import tcr_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic conv_start,
	input wire logic [TCR_VAL_W-1:0] value,
	input wire logic [3:0] delay,
	output logic conv_done,
	output logic [TCR_VAL_W-1:0] conv_value
);
	logic [3:0] left_q;
	logic [TCR_VAL_W-1:0] last_q;
	// ****************************************
	// conversion timing
	// ****************************************
	// value line shows the inverse outside the done cycle, so a late sample is caught
	always_ff @(posedge sys_clk) begin
		conv_done <= 1'b0;
		conv_value <= ~last_q;
		if (!rst_n) begin
			left_q <= 4'h0;
			last_q <= '0;
		end else if (conv_start) begin
			left_q <= delay;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
			if (left_q == 4'h1) begin
				conv_done <= 1'b1;
				conv_value <= value;
				last_q <= value;
			end
		end
	end
endmodule

// ===== tb/tcr_readout_tb.sv
// self-checking bench of the thermocouple channel readout
`timescale 1ns/1ps
module tcr_readout_tb import tcr_pkg::*;;
	// ****************************************
	// shortened counts and signals
	// ****************************************
	localparam tcr_cnt_t S_EXT = 24'h28;
	localparam tcr_cnt_t S_EXT_LF = 24'h50;
	localparam tcr_cnt_t S_INT = 24'h78;
	localparam tcr_cnt_t S_INT_LF = 24'ha0;
	localparam tcr_cnt_t S_SEND = 24'h1e;
	localparam tcr_cnt_t S_FAST = 24'h2;
	localparam tcr_cnt_t S_MID = 24'h3;
	localparam tcr_cnt_t S_SLOW = 24'h5;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic line_break_pin = 1'b0;
	logic prm_valid = 1'b0;
	logic [7:0] prm_header = 8'h00;
	logic [7:0] prm_data1 = 8'h00;
	logic [7:0] prm_data2 = 8'h00;
	logic [11:0] mval = 12'h000;
	logic [3:0] mdly = 4'h1;
	logic conv_done, conv_start, word_strobe, diag_fault;
	logic cjc_ext_sel, cjc_ref_50c, cjc_comp_en;
	logic [11:0] conv_value;
	logic [15:0] chan_word;
	logic [7:0] cfg_code, cfg_in_bytes, cfg_out_bytes;
	logic [15:0] cj_now;
	assign cj_now = {13'h0000, cjc_ext_sel, cjc_ref_50c, cjc_comp_en};
	logic [15:0] last_w = 16'h0000;
	logic [7:0] modes [4] = '{8'h08, 8'h09, 8'h00, 8'h01};
	int bad_count = 0;
	int checks_done = 0;
	int seed = 34;
	int cycles = 0;
	always #20 sys_clk = ~sys_clk;
	tcr_readout #(.N_EXT(S_EXT), .N_EXT_LF(S_EXT_LF), .N_INT(S_INT), .N_INT_LF(S_INT_LF),
		.N_SEND(S_SEND), .N_RAMP_FAST(S_FAST), .N_RAMP_MID(S_MID), .N_RAMP_SLOW(S_SLOW)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .conv_done(conv_done), .conv_value(conv_value),
		.line_break_pin(line_break_pin), .prm_valid(prm_valid), .prm_header(prm_header),
		.prm_data1(prm_data1), .prm_data2(prm_data2), .chan_word(chan_word),
		.word_strobe(word_strobe), .conv_start(conv_start), .diag_fault(diag_fault),
		.cjc_ext_sel(cjc_ext_sel), .cjc_ref_50c(cjc_ref_50c), .cjc_comp_en(cjc_comp_en),
		.cfg_code(cfg_code), .cfg_in_bytes(cfg_in_bytes), .cfg_out_bytes(cfg_out_bytes));
	tcr_conv_model conv (.sys_clk(sys_clk), .rst_n(rst_n), .conv_start(conv_start), .value(mval),
		.delay(mdly), .conv_done(conv_done), .conv_value(conv_value));
	// ****************************************
	// checking helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_near(input int got, input int exp, input int tol, input string what);
		checks_done++;
		if (got < exp - tol || got > exp + tol) begin
			bad_count++;
			$display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	function automatic logic pulse(input int s);
		return (s == 0) ? conv_start : (s == 1) ? word_strobe : conv_done;
	endfunction
	// expected {external, 50 degC, compensation}; internal junction ignores the temperature bit
	function automatic logic [15:0] cj_exp(input logic [7:0] d1);
		case (d1[4:3])
			2'b01: return 16'h0004;
			2'b11: return 16'h0007;
			default: return 16'h0001;
		endcase
	endfunction
	function automatic int per(input logic [7:0] d1);
		if (d1[3]) return d1[0] ? int'(S_EXT_LF) : int'(S_EXT);
		return d1[0] ? int'(S_INT_LF) : int'(S_INT);
	endfunction
	function automatic int step(input int c);
		return int'(S_SEND) / ((c == 1) ? int'(S_FAST) : (c == 2) ? int'(S_MID) : int'(S_SLOW));
	endfunction
	// reads at the edge see the cycle just ended, the same values the design samples
	task automatic wait_for(input int s);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pulse(s) !== 1'b1 && n < 400);
		if (n >= 400) begin
			bad_count++;
			$display("[ERR] %0t pulse %0d missing", $time, s);
		end
	endtask
	task automatic gap(input int s, output int n);
		wait_for(s);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pulse(s) !== 1'b1 && n < 400);
	endtask
	task automatic set_prm(input logic [7:0] hdr, input logic [7:0] d1);
		prm_valid <= 1'b1;
		prm_header <= hdr;
		prm_data1 <= d1;
		prm_data2 <= 8'($random(seed));
		@(posedge sys_clk);
		prm_valid <= 1'b0;
		prm_header <= 8'($random(seed));
		@(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		mdly <= 4'h1 + 4'($random(seed) & 7);
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			$display("[ERR] %0t run hung", $time);
			conclude();
		end
		if (rst_n === 1'b1) begin
			chk({12'h000, chan_word[3:0] & 4'hd}, 16'h0000, "empty word bits");
			if (word_strobe !== 1'b1) chk(chan_word, last_w, "word between sends");
		end
		last_w = chan_word;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int g;
		int d;
		logic [7:0] d1;
		logic [11:0] v;
		logic [11:0] cur;
		logic [11:0] vals [4];
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk(cj_now, cj_exp(8'h00), "reset");
		chk({cfg_code, cfg_in_bytes}, 16'h5002, "config code");
		chk({8'h00, cfg_out_bytes}, 16'h0000, "no out bytes");
		gap(0, g);
		chk_near(g, per(8'h00), 0, "default period");
		$display("test defaults done");
		for (int i = 0; i < 32; i++) begin
			d1 = {3'($random(seed)), 5'(i)};
			set_prm(8'h52, d1);
			chk(cj_now, cj_exp(d1), "decode");
		end
		set_prm(8'h51, 8'h00);
		chk(cj_now, cj_exp(d1), "bad header");
		$display("test parameters done");
		foreach (modes[k]) begin
			set_prm(8'h52, modes[k]);
			gap(0, g);
			gap(0, g);
			chk_near(g, per(modes[k]), 0, "period");
		end
		gap(1, g);
		chk_near(g, int'(S_SEND), 0, "send period");
		$display("test periods done");
		set_prm(8'h52, 8'h08);
		vals = '{12'hfff, 12'h000, 12'($random(seed)), 12'($random(seed))};
		foreach (vals[k]) begin
			mval <= vals[k];
			wait_for(2);
			wait_for(2);
			repeat (3) @(posedge sys_clk);
			wait_for(1);
			chk(chan_word, {vals[k], 4'h0}, "value path");
		end
		cur = vals[3];
		$display("test values done");
		for (int c = 1; c < 4; c++) begin
			v = (cur < 12'h800) ? cur + 12'h700 : cur - 12'h700;
			set_prm(8'h52, 8'h08 | 8'(c << 1));
			mval <= v;
			wait_for(2);
			wait_for(2);
			wait_for(1);
			g = int'(chan_word[15:4]);
			wait_for(1);
			d = int'(chan_word[15:4]) - g;
			chk_near((cur < 12'h800) ? d : -d, step(c), 1, "ramp rate");
			set_prm(8'h52, 8'h08);
			wait_for(2);
			wait_for(2);
			repeat (3) @(posedge sys_clk);
			wait_for(1);
			chk(chan_word, {v, 4'h0}, "filter off");
			cur = v;
		end
		$display("test filter done");
		set_prm(8'h52, 8'h09);
		wait_for(2);
		line_break_pin <= 1'b1;
		mval <= ~cur;
		wait_for(2);
		@(posedge sys_clk);
		chk({15'h0000, diag_fault}, 16'h0001, "fault flagged");
		wait_for(1);
		chk(chan_word, {cur, 4'h2}, "value held");
		line_break_pin <= 1'b0;
		v = 12'($random(seed));
		mval <= v;
		for (int i = 1; i <= 10; i++) begin
			wait_for(2);
			@(posedge sys_clk);
			chk({15'h0000, diag_fault}, {15'h0000, i < 10}, "release count");
		end
		wait_for(1);
		chk(chan_word, {v, 4'h0}, "value released");
		set_prm(8'h52, 8'h08);
		line_break_pin <= 1'b1;
		mval <= ~v;
		wait_for(2);
		wait_for(2);
		@(posedge sys_clk);
		chk({15'h0000, diag_fault}, 16'h0000, "fault when off");
		wait_for(1);
		chk(chan_word, {~v, 4'h0}, "value when off");
		$display("test line fault done");
		conclude();
	end
endmodule
